/* File: rtl/fsc_host.sv */
// apb-programmed host controller for the flash status pin and block locks
// assumes the flash answers within the access times held in fsc_pkg
//
// The implementer's own choice: the APB slave port.
`timescale 1ns/1ps
`default_nettype none
module fsc_host (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    output logic      [23:0] flash_addr,
    input  wire logic [15:0] flash_dq_i,
    output logic      [15:0] flash_dq_o,
    output logic             flash_dq_oe,
    output logic             flash_ce_n,
    output logic             flash_oe_n,
    output logic             flash_we_n,
    output logic             flash_rst_n,
    input  wire logic        status_pin
);

    // ****************************************
    // apb slave
    // ****************************************
    fsc_pkg::fsc_step_t step_q;
    fsc_pkg::fsc_eng_t  eng_q;
    logic [2:0]  op_q;
    logic [23:0] blk_q;
    logic [7:0]  cfg_q;
    logic [7:0]  sr_q;
    logic        lock_q;
    logic        rst_q;
    logic [15:0] rd_q;
    logic [3:0]  cnt_q;
    logic        wr_q;
    logic [23:0] pin_addr_q;
    logic [15:0] pin_data_q;

    wire wr_en     = psel && penable && pwrite;
    wire hit_cmd   = (paddr == fsc_pkg::REG_CMD);
    wire hit_addr  = (paddr == fsc_pkg::REG_ADDR);
    wire hit_cfg   = (paddr == fsc_pkg::REG_CFG);
    wire hit_stat  = (paddr == fsc_pkg::REG_STAT);
    wire hit_reset = (paddr == fsc_pkg::REG_RESET);
    wire mapped    = hit_cmd || hit_addr || hit_cfg || hit_stat || hit_reset;
    wire busy      = (step_q != fsc_pkg::ST_IDLE);
    // a new order while busy is dropped; software polls the busy bit
    wire start     = wr_en && hit_cmd && !busy && !rst_q;

    assign pready  = 1'b1;
    assign pslverr = psel && penable && !mapped;

    wire [31:0] stat_word = {16'h0000, sr_q, 5'h00, status_pin, lock_q, busy};
    assign prdata = hit_cmd   ? {29'h0, op_q} :
                    hit_addr  ? {8'h00, blk_q} :
                    hit_cfg   ? {24'h0, cfg_q} :
                    hit_stat  ? stat_word :
                    hit_reset ? {31'h0, rst_q} : 32'h0;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            blk_q <= 24'h0;
            cfg_q <= 8'h00;
            rst_q <= 1'b0;
        end else begin
            if (wr_en && hit_addr) blk_q <= pwdata[23:0];
            if (wr_en && hit_cfg) cfg_q <= pwdata[7:0];
            if (wr_en && hit_reset) rst_q <= pwdata[0];
        end
    end

    // ****************************************
    // command sequencer
    // ****************************************
    function automatic logic [15:0] setup_code(input logic [2:0] op);
        unique case (op)
            fsc_pkg::OP_CFG:   setup_code = fsc_pkg::CMD_PIN_SETUP;
            fsc_pkg::OP_RDLK:  setup_code = fsc_pkg::CMD_READ_INFO;
            fsc_pkg::OP_CLRST: setup_code = fsc_pkg::CMD_CLR_STATUS;
            default:           setup_code = fsc_pkg::CMD_LOCK_SETUP;
        endcase
    endfunction : setup_code

    wire bus_done   = (eng_q == fsc_pkg::E_REC) && (cnt_q == fsc_pkg::REC_CYC);
    wire acc_end    = (eng_q == fsc_pkg::E_ACT) && (cnt_q == (wr_q ? fsc_pkg::WE_CYC : fsc_pkg::ACC_CYC));
    wire rd_ready   = rd_q[fsc_pkg::SR_READY_BIT];
    wire rd_suspend = rd_q[fsc_pkg::SR_ERS_SUSP_BIT] || rd_q[fsc_pkg::SR_PRG_SUSP_BIT];
    wire is_cfg     = (op_q == fsc_pkg::OP_CFG);
    wire [15:0] confirm_code = is_cfg ? {8'h00, cfg_q} :
                               (op_q == fsc_pkg::OP_LOCK) ? fsc_pkg::CMD_LOCK_CONFIRM :
                               fsc_pkg::CMD_CLR_CONFIRM;

    logic [15:0] cur_data;
    logic        cur_wr;
    logic [23:0] cur_addr;
    fsc_pkg::fsc_step_t step_d;

    always_comb begin
        cur_data = fsc_pkg::DATA_IDLE;
        cur_wr   = 1'b1;
        cur_addr = blk_q;
        step_d   = step_q;
        unique case (step_q)
            fsc_pkg::ST_IDLE: begin
                if (start) step_d = (pwdata[2:0] == fsc_pkg::OP_CFG) ? fsc_pkg::ST_RS_CMD : fsc_pkg::ST_SETUP;
            end
            fsc_pkg::ST_RS_CMD: begin
                cur_data = fsc_pkg::CMD_READ_STATUS;
                if (bus_done) step_d = fsc_pkg::ST_RS_RD;
            end
            fsc_pkg::ST_RS_RD: begin
                cur_wr = 1'b0;
                // configure only when ready and not suspended
                if (bus_done && rd_ready && !rd_suspend) step_d = fsc_pkg::ST_SETUP;
            end
            fsc_pkg::ST_SETUP: begin
                cur_data = setup_code(op_q);
                if (bus_done) begin
                    if (op_q == fsc_pkg::OP_CLRST) step_d = fsc_pkg::ST_IDLE;
                    else if (op_q == fsc_pkg::OP_RDLK) step_d = fsc_pkg::ST_ID_RD;
                    else step_d = fsc_pkg::ST_CONFIRM;
                end
            end
            fsc_pkg::ST_CONFIRM: begin
                cur_data = confirm_code;
                if (bus_done) step_d = is_cfg ? fsc_pkg::ST_IDLE : fsc_pkg::ST_POLL;
            end
            fsc_pkg::ST_POLL: begin
                cur_wr = 1'b0;
                // reads already return status after a lock setup
                if (bus_done && rd_ready) step_d = fsc_pkg::ST_IDLE;
            end
            fsc_pkg::ST_ID_RD: begin
                cur_wr   = 1'b0;
                cur_addr = 24'(blk_q + fsc_pkg::LOCK_STATE_OFS);
                if (bus_done) step_d = fsc_pkg::ST_ARRAY;
            end
            fsc_pkg::ST_ARRAY: begin
                cur_data = fsc_pkg::CMD_READ_ARRAY;
                if (bus_done) step_d = fsc_pkg::ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            step_q <= fsc_pkg::ST_IDLE;
            op_q   <= fsc_pkg::OP_CFG;
            sr_q   <= 8'h00;
            lock_q <= 1'b0;
        end else begin
            step_q <= step_d;
            if (start) op_q <= pwdata[2:0];
            if (bus_done && (step_q == fsc_pkg::ST_RS_RD || step_q == fsc_pkg::ST_POLL)) sr_q <= rd_q[7:0];
            if (bus_done && step_q == fsc_pkg::ST_ID_RD) lock_q <= rd_q[fsc_pkg::LOCK_DATA_BIT];
        end
    end

    // ****************************************
    // flash bus cycle engine
    // ****************************************
    wire eng_start = (eng_q == fsc_pkg::E_IDLE) && busy;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            eng_q      <= fsc_pkg::E_IDLE;
            cnt_q      <= 4'h0;
            wr_q       <= 1'b0;
            pin_addr_q <= 24'h0;
            pin_data_q <= 16'h0;
            rd_q       <= 16'h0;
        end else begin
            unique case (eng_q)
                fsc_pkg::E_IDLE: begin
                    if (eng_start) begin
                        eng_q      <= fsc_pkg::E_ACT;
                        cnt_q      <= fsc_pkg::CNT_ONE;
                        wr_q       <= cur_wr;
                        pin_addr_q <= cur_addr;
                        pin_data_q <= cur_data;
                    end
                end
                fsc_pkg::E_ACT: begin
                    cnt_q <= acc_end ? fsc_pkg::CNT_ONE : 4'(cnt_q + fsc_pkg::CNT_ONE);
                    if (acc_end) eng_q <= fsc_pkg::E_REC;
                    if (acc_end && !wr_q) rd_q <= flash_dq_i;
                end
                fsc_pkg::E_REC: begin
                    cnt_q <= bus_done ? 4'h0 : 4'(cnt_q + fsc_pkg::CNT_ONE);
                    if (bus_done) eng_q <= fsc_pkg::E_IDLE;
                end
            endcase
        end
    end

    // data stays driven through recovery to cover the hold time
    assign flash_addr  = pin_addr_q;
    assign flash_dq_o  = pin_data_q;
    assign flash_dq_oe = (eng_q != fsc_pkg::E_IDLE) && wr_q;
    assign flash_ce_n  = (eng_q != fsc_pkg::E_ACT);
    assign flash_we_n  = !((eng_q == fsc_pkg::E_ACT) && wr_q);
    assign flash_oe_n  = !((eng_q == fsc_pkg::E_ACT) && !wr_q);
    assign flash_rst_n = !rst_q;

    // ****************************************
    // checks
    // ****************************************
    sequence s_setup_done(logic [2:0] op);
        (step_q == fsc_pkg::ST_SETUP) && (op_q == op) && bus_done;
    endsequence

    chk_cfg_pair_order: assert property (@(posedge pclk) disable iff (!presetn)
        s_setup_done(fsc_pkg::OP_CFG) |=> (step_q == fsc_pkg::ST_CONFIRM) ##1 (pin_data_q == {8'h00, cfg_q}))
        else $error("configuration code did not follow pin setup");

    chk_cfg_when_ready: assert property (@(posedge pclk) disable iff (!presetn)
        (eng_start && step_q == fsc_pkg::ST_SETUP && is_cfg)
            |-> sr_q[fsc_pkg::SR_READY_BIT] && !sr_q[fsc_pkg::SR_ERS_SUSP_BIT] && !sr_q[fsc_pkg::SR_PRG_SUSP_BIT])
        else $error("pin setup issued while busy or suspended");

    chk_lock_same_block: assert property (@(posedge pclk) disable iff (!presetn)
        s_setup_done(fsc_pkg::OP_LOCK) ##2 (eng_q == fsc_pkg::E_ACT)
            |-> (pin_addr_q == blk_q) && (pin_data_q == fsc_pkg::CMD_LOCK_CONFIRM))
        else $error("lock confirm not sent to the set-up block");

    chk_clear_pair: assert property (@(posedge pclk) disable iff (!presetn)
        s_setup_done(fsc_pkg::OP_CLR) |-> $past(pin_data_q, 1) == fsc_pkg::CMD_LOCK_SETUP
            ##2 pin_data_q == fsc_pkg::CMD_CLR_CONFIRM)
        else $error("clear-locks pair out of order");

    chk_clear_status: assert property (@(posedge pclk) disable iff (!presetn)
        (start && pwdata[2:0] == fsc_pkg::OP_CLRST)
            |=> ##1 (!flash_we_n && pin_data_q == fsc_pkg::CMD_CLR_STATUS))
        else $error("clear-status command not issued");

    chk_we_data_stable: assert property (@(posedge pclk) disable iff (!presetn)
        (!flash_we_n && !$past(flash_we_n)) |-> $stable(flash_dq_o) && $stable(flash_addr))
        else $error("write data moved during write strobe");

endmodule : fsc_host
`default_nettype wire

/* File: rtl/fsc_pkg.sv */
// constants for the flash status-pin and block-lock host controller
// assumes a 100 MHz pclk and a 16-bit asynchronous parallel flash
//
// Contract
// - host writes 00B8h then configuration code
// - host configures only when ready, not suspended
// - lock block: 0060h, 0001h to block
// - clear all locks: 0060h, 00D0h
// - lock errors flagged; host clears with clear-status
package fsc_pkg;

    // ****************************************
    // flash command codes
    // ****************************************
    localparam logic [15:0] CMD_READ_STATUS  = 16'h0070;
    localparam logic [15:0] CMD_PIN_SETUP    = 16'h00B8;
    localparam logic [15:0] CMD_LOCK_SETUP   = 16'h0060;
    localparam logic [15:0] CMD_LOCK_CONFIRM = 16'h0001;
    localparam logic [15:0] CMD_CLR_CONFIRM  = 16'h00D0;
    localparam logic [15:0] CMD_READ_INFO    = 16'h0090;
    localparam logic [15:0] CMD_READ_ARRAY   = 16'h00FF;
    localparam logic [15:0] CMD_CLR_STATUS   = 16'h0050;
    localparam logic [15:0] DATA_IDLE        = 16'h0000;

    localparam logic [23:0] LOCK_STATE_OFS   = 24'h000002;
    localparam logic [23:0] ADDR_ZERO        = 24'h000000;

    // status register and lock-state bit positions
    localparam int SR_READY_BIT    = 7;
    localparam int SR_ERS_SUSP_BIT = 6;
    localparam int SR_PRG_SUSP_BIT = 2;
    localparam int LOCK_DATA_BIT   = 0;

    // ****************************************
    // flash bus timing
    // ****************************************
    localparam int CLK_PERIOD_NS = 10;
    localparam int T_WE_NS       = 70;
    localparam int T_ACC_NS      = 75;
    localparam int T_REC_NS      = 30;
    localparam logic [3:0] WE_CYC  = 4'((T_WE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [3:0] ACC_CYC = 4'((T_ACC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [3:0] REC_CYC = 4'((T_REC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [3:0] CNT_ONE = 4'h1;

    // ****************************************
    // apb register map
    // ****************************************
    localparam logic [7:0] REG_CMD   = 8'h00;
    localparam logic [7:0] REG_ADDR  = 8'h04;
    localparam logic [7:0] REG_CFG   = 8'h08;
    localparam logic [7:0] REG_STAT  = 8'h0C;
    localparam logic [7:0] REG_RESET = 8'h10;

    localparam int STAT_BUSY_BIT = 0;
    localparam int STAT_LOCK_BIT = 1;
    localparam int STAT_PIN_BIT  = 2;
    localparam int STAT_SR_LSB   = 8;

    typedef enum logic [2:0] {
        OP_CFG   = 3'h0,
        OP_LOCK  = 3'h1,
        OP_CLR   = 3'h2,
        OP_RDLK  = 3'h3,
        OP_CLRST = 3'h4
    } fsc_op_t;

    typedef enum {
        ST_IDLE, ST_RS_CMD, ST_RS_RD, ST_SETUP, ST_CONFIRM, ST_POLL, ST_ID_RD, ST_ARRAY
    } fsc_step_t;

    typedef enum { E_IDLE, E_ACT, E_REC } fsc_eng_t;

endpackage : fsc_pkg

/* File: verification/fsc_flash_model.sv */
// behavioural flash device: command decode, status pin and block lock bits
// assumes the host holds address and data steady until flash_we_n rises
`timescale 1ns/1ps
`default_nettype none
module fsc_flash_model #(
    parameter int BUSY_NS = 400
) (
    input  wire logic [23:0] flash_addr,
    input  wire logic [15:0] dq_in,
    input  wire logic        flash_ce_n,
    input  wire logic        flash_oe_n,
    input  wire logic        flash_we_n,
    input  wire logic        flash_rst_n,
    input  wire logic        program_enable_voltage_ok,
    output logic      [15:0] dq_out,
    output logic             status_pin
);
    // ****************************************
    // device state
    // ****************************************
    // erase and program are not modelled, so a set bit only shows on readback
    logic             lock_q [256];
    logic [1:0]       pin_mode_q = 2'h0;
    logic [1:0]       rd_mode_q  = 2'h0;
    logic [15:0]      pend_q     = 16'h0000;
    logic             busy_q     = 1'b0;
    logic [7:0]       err_q      = 8'h00;
    logic [15:0]      hold_q     = 16'hA5A5;
    logic [15:0]      rd_val;
    logic             chg_ok;
    event             op_ev;
    wire logic        rd_en = !flash_ce_n && !flash_oe_n;
    wire logic [7:0]  blk   = flash_addr[23:16];

    initial foreach (lock_q[i]) lock_q[i] = 1'b0;
    always @(op_ev) begin
        busy_q = 1'b1;
        #(BUSY_NS);
        busy_q = 1'b0;
    end
    // lock bits are left alone here: they must survive a reset
    always @(negedge flash_rst_n) begin
        pin_mode_q = 2'h0;
        rd_mode_q = 2'h0;
        pend_q = 16'h0000;
    end
    always @(posedge flash_we_n) begin
        chg_ok = program_enable_voltage_ok && !busy_q;
        if (pend_q == fsc_pkg::CMD_PIN_SETUP) begin
            if (dq_in[1:0] == 2'h2) err_q = err_q | 8'h30;
            else pin_mode_q = dq_in[1:0];
            pend_q = 16'h0000;
        end else if (pend_q == fsc_pkg::CMD_LOCK_SETUP) begin
            pend_q = 16'h0000;
            -> op_ev;
            if (dq_in == fsc_pkg::CMD_LOCK_CONFIRM && chg_ok) lock_q[blk] = 1'b1;
            else if (dq_in == fsc_pkg::CMD_CLR_CONFIRM && chg_ok) foreach (lock_q[i]) lock_q[i] = 1'b0;
            else if (dq_in == fsc_pkg::CMD_CLR_CONFIRM) err_q = err_q | 8'h20;
            else err_q = err_q | 8'h10;
        end else begin
            if (dq_in == fsc_pkg::CMD_PIN_SETUP || dq_in == fsc_pkg::CMD_LOCK_SETUP) pend_q = dq_in;
            if (dq_in == fsc_pkg::CMD_LOCK_SETUP || dq_in == fsc_pkg::CMD_READ_STATUS) rd_mode_q = 2'h1;
            if (dq_in == fsc_pkg::CMD_READ_INFO) rd_mode_q = 2'h2;
            if (dq_in == fsc_pkg::CMD_READ_ARRAY) rd_mode_q = 2'h0;
            if (dq_in == fsc_pkg::CMD_CLR_STATUS) err_q = 8'h00;
        end
    end
    always_comb begin
        rd_val = flash_addr[15:0] ^ 16'h5A5A;
        if (rd_mode_q == 2'h1) rd_val = {8'h00, ~busy_q, err_q[6:0]};
        if (rd_mode_q == 2'h2) rd_val = {15'h0, lock_q[blk] && flash_addr[15:0] == 16'h0002};
    end
    // released bus shows the inverse of the last word, never a stale match
    always @(rd_val or rd_en) if (rd_en) hold_q = ~rd_val;
    assign dq_out     = rd_en ? rd_val : hold_q;
    assign status_pin = (pin_mode_q == 2'h0) ? ~busy_q : 1'b1;
endmodule : fsc_flash_model
`default_nettype wire

/* File: verification/testbench.sv */
// self-checking bench for the flash status-pin and block-lock host controller
// assumes fsc_flash_model on the flash side; apb master and reference model live here
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic             pclk, presetn, psel, penable, pwrite, pready, pslverr, program_enable_voltage_ok, e;
    logic [7:0]       paddr;
    logic [31:0]      pwdata, prdata, q;
    logic [23:0]      flash_addr;
    logic [15:0]      flash_dq_o, mdl_dq;
    logic             flash_dq_oe, flash_ce_n, flash_oe_n, flash_we_n, flash_rst_n, status_pin;
    int               mismatches, num_checks, cycles, pin_low, mode_m, err_m, b1;
    int               lock_m [256];
    wire logic [15:0] dq_bus = flash_dq_oe ? flash_dq_o : mdl_dq;

    fsc_host u_fsc_host (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .flash_addr(flash_addr), .flash_dq_i(dq_bus), .flash_dq_o(flash_dq_o), .flash_dq_oe(flash_dq_oe),
        .flash_ce_n(flash_ce_n), .flash_oe_n(flash_oe_n), .flash_we_n(flash_we_n),
        .flash_rst_n(flash_rst_n), .status_pin(status_pin));
    fsc_flash_model u_fsc_flash_model (.flash_addr(flash_addr), .dq_in(dq_bus), .flash_ce_n(flash_ce_n),
        .flash_oe_n(flash_oe_n), .flash_we_n(flash_we_n), .flash_rst_n(flash_rst_n), .program_enable_voltage_ok(program_enable_voltage_ok),
        .dq_out(mdl_dq), .status_pin(status_pin));

    initial pclk = 1'b0;
    always #5 pclk = ~pclk;
    always @(posedge pclk) begin
        cycles++;
        if (status_pin === 1'b0) pin_low++;
        if (cycles == 60000) begin
            mismatches++;
            tally_and_finish();
        end
    end

    // ****************************************
    // bus and compare tasks
    // ****************************************
    task automatic chk(input logic [31:0] s, input logic [31:0] x);
        num_checks++;
        if (s !== x) begin
            mismatches++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, s, x);
        end
    endtask : chk
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : apb
    task automatic run_op(input logic [2:0] op);
        apb(1'b1, fsc_pkg::REG_CMD, {29'h0, op});
        for (int i = 0; i < 500; i++) begin
            apb(1'b0, fsc_pkg::REG_STAT, 32'h0);
            if (q[0] === 1'b0) break;
        end
    endtask : run_op
    task automatic lock_op(input int blk, input logic [2:0] op);
        pin_low = 0;
        apb(1'b1, fsc_pkg::REG_ADDR, {8'h00, 8'(blk), 16'h0000});
        run_op(op);
        if (!program_enable_voltage_ok) err_m = err_m | ((op == fsc_pkg::OP_LOCK) ? 'h10 : 'h20);
        else if (op == fsc_pkg::OP_LOCK) lock_m[blk] = 1;
        else foreach (lock_m[i]) lock_m[i] = 0;
        chk(32'(q[15:8]), 32'(8'h80 | err_m));
        chk(32'(q[2]), 32'h1);
        chk(32'(pin_low > 0), 32'(mode_m == 0));
    endtask : lock_op
    task automatic read_lock(input int blk);
        apb(1'b1, fsc_pkg::REG_ADDR, {8'h00, 8'(blk), 16'h0000});
        run_op(fsc_pkg::OP_RDLK);
        chk(32'(q[1]), 32'(lock_m[blk]));
    endtask : read_lock
    task automatic cfg_op(input logic [1:0] code);
        apb(1'b1, fsc_pkg::REG_CFG, {24'h0, 6'($urandom), code});
        run_op(fsc_pkg::OP_CFG);
        chk(32'(q[15:8]), 32'(8'h80 | err_m));
        if (code == 2'h2) err_m = err_m | 'h30;
        else mode_m = code;
    endtask : cfg_op
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : tally_and_finish

    // ****************************************
    // main sequence
    // ****************************************
    initial begin
        {psel, penable, pwrite, presetn} = 4'h0;
        paddr = 8'h00;
        pwdata = 32'h0000_0000;
        program_enable_voltage_ok = 1'b1;
        void'($urandom(32'hA7B7));
        b1 = $urandom_range(63, 0);
        foreach (lock_m[i]) lock_m[i] = 0;
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        for (int i = 0; i < 5; i++) begin
            apb(1'b0, 8'(4 * i), 32'h0);
            chk(q, (i == 3) ? 32'h0000_0004 : 32'h0000_0000);
        end
        apb(1'b1, 8'h14, 32'hFFFF_FFFF);
        chk(32'(e), 32'h1);
        lock_op(b1, fsc_pkg::OP_LOCK);
        read_lock(b1);
        read_lock(b1 + 64);
        cfg_op(2'h1);
        cfg_op(2'h2);
        lock_op(b1 + 64, fsc_pkg::OP_LOCK);
        run_op(fsc_pkg::OP_CLRST);
        err_m = 0;
        cfg_op(2'h3);
        cfg_op(2'h0);
        cfg_op(2'h3);
        apb(1'b1, fsc_pkg::REG_RESET, 32'h1);
        apb(1'b1, fsc_pkg::REG_RESET, 32'h0);
        mode_m = 0;
        read_lock(b1 + 64);
        lock_op(b1 + 128, fsc_pkg::OP_LOCK);
        program_enable_voltage_ok <= 1'b0;
        lock_op(b1 + 192, fsc_pkg::OP_LOCK);
        lock_op(b1, fsc_pkg::OP_CLR);
        read_lock(b1);
        read_lock(b1 + 192);
        program_enable_voltage_ok <= 1'b1;
        run_op(fsc_pkg::OP_CLRST);
        err_m = 0;
        lock_op(b1, fsc_pkg::OP_CLR);
        read_lock(b1);
        read_lock(b1 + 128);
        tally_and_finish();
    end
endmodule : testbench
`default_nettype wire
